// ==== rtl/capture_fifo.sv ====
`timescale 1ns/1ps
module capture_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg];
  assign level     = count_reg;

  // Payload storage carries no reset: captured words have no defined start value
  always_ff @(posedge mclk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : capture_fifo

// ==== rtl/latched_shifter.sv ====
`timescale 1ns/1ps
module latched_shifter
  import shifter_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  // Serial side pins
  input  wire logic                    shift_data_in,
  input  wire logic                    shift_clock,
  input  wire logic                    shift_clear_n,
  input  wire logic                    storage_clock,
  input  wire logic                    output_enable_n,
  // Drain stall for the capture queue
  input  wire logic                    update_hold,
  // Parallel three-state outputs
  output shifter_pkg::stage_word_t     par_out,
  output logic                         par_oe,
  // Cascade output
  output logic                         cascade_out,
  // Capture queue status
  output logic                         capture_ready,
  output logic                         capture_dropped,
  output logic [$clog2(shifter_pkg::CAPTURE_DEPTH):0] capture_level
);
  import shifter_pkg::*;

  pin_in_t     pins_raw;
  pin_in_t     pins_s;
  pin_in_t     pins_rise;
  stage_word_t chain_reg;
  stage_word_t chain_next;
  stage_word_t storage_reg;
  stage_word_t drain_data;
  logic        drain_valid;
  logic        drain_ready;
  logic        shift_edge;
  logic        store_edge;
  logic        clear_active;
  logic        oe_reg;
  logic        dropped_reg;

  assign pins_raw = '{
    serial:    shift_data_in,
    shift_clk: shift_clock,
    clear_n:   shift_clear_n,
    store_clk: storage_clock,
    oe_n:      output_enable_n,
    hold:      update_hold
  };

  // Every pin, clocks included, sees the same latency so data stays aligned
  pin_sampler #(
    .W       (PIN_COUNT),
    .RST_VAL (PIN_IDLE)
  ) u_sampler (
    .mclk     (mclk),
    .nrst     (nrst),
    .pin_raw  (pins_raw),
    .pin_sync (pins_s),
    .pin_rise (pins_rise)
  );

  assign shift_edge   = pins_rise.shift_clk;
  assign store_edge   = pins_rise.store_clk;
  assign clear_active = !pins_s.clear_n;

  // Clear overrides shifting; falling clock edges fall through to hold
  always_comb
  begin
    chain_next = chain_reg;
    if (clear_active)
      chain_next = STAGE_ZERO;
    else if (shift_edge)
      chain_next = {chain_reg[LAST_STAGE-1:0], pins_s.serial};
  end

  // No reset on purpose: the chain has no defined start value
  always_ff @(posedge mclk)
  begin
    chain_reg <= chain_next;
  end

  assign cascade_out = chain_reg[LAST_STAGE];

  // Captures push the pre-shift chain; the queue feeds storage on mclk whenever the drain is not held
  capture_fifo #(
    .WIDTH (NUM_STAGES),
    .DEPTH (CAPTURE_DEPTH)
  ) u_queue (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (store_edge),
    .in_ready  (capture_ready),
    .in_data   (chain_reg),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data),
    .level     (capture_level)
  );

  assign drain_ready = !pins_s.hold;

  // Storage changes only on a drained capture, never on clear
  always_ff @(posedge mclk)
  begin
    if (drain_valid && drain_ready)
      storage_reg <= drain_data;
  end

  // A capture arriving on a full queue is lost; report it for one cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      dropped_reg <= 1'b0;
    else
      dropped_reg <= store_edge && !capture_ready;
  end

  assign capture_dropped = dropped_reg;

  // Enable is a registered copy so the driven window never glitches
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      oe_reg <= 1'b0;
    else
      oe_reg <= !pins_s.oe_n;
  end

  assign par_out = storage_reg;
  assign par_oe  = oe_reg;

  // Clear low forces an all-zero chain next cycle
  property p_clear_zero;
    @(posedge mclk) disable iff (!nrst)
    clear_active |=> (chain_reg == STAGE_ZERO);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("chain not zero after clear");

  // Shift edge moves every stage by one and loads serial data
  property p_shift_step;
    @(posedge mclk) disable iff (!nrst)
    (shift_edge && !clear_active)
      |=> (chain_reg == {$past(chain_reg[LAST_STAGE-1:0]), $past(pins_s.serial)});
  endproperty
  a_shift_step: assert property (p_shift_step)
    else $error("shift step wrong");

  // Without a rising edge or clear the chain holds
  property p_chain_hold;
    @(posedge mclk) disable iff (!nrst)
    (!shift_edge && !clear_active) |=> $stable(chain_reg);
  endproperty
  a_chain_hold: assert property (p_chain_hold)
    else $error("chain moved without rising edge");

  // Cascade output changes only after a shift edge or clear
  property p_cascade_cause;
    @(posedge mclk) disable iff (!nrst)
    !$stable(cascade_out) |-> $past(shift_edge || clear_active);
  endproperty
  a_cascade_cause: assert property (p_cascade_cause)
    else $error("cascade changed without cause");

  // Enable pin level reaches the output enable exactly one cycle later
  property p_enable_follow;
    @(posedge mclk) disable iff (!nrst)
    pins_s.oe_n ##1 pins_s.oe_n |-> !par_oe;
  endproperty
  a_enable_follow: assert property (p_enable_follow)
    else $error("parallel outputs driven while disabled");

  property p_enable_drive;
    @(posedge mclk) disable iff (!nrst)
    !pins_s.oe_n |=> par_oe;
  endproperty
  a_enable_drive: assert property (p_enable_drive)
    else $error("parallel outputs not driven while enabled");

  // Tied clocks into an empty, unstalled queue: storage shows the pre-shift chain
  property p_tied_lag;
    @(posedge mclk) disable iff (!nrst)
    (store_edge && shift_edge && !drain_valid && drain_ready) ##1 drain_ready
      |=> (storage_reg == $past(chain_reg, 2));
  endproperty
  a_tied_lag: assert property (p_tied_lag)
    else $error("storage did not lag the chain by one shift");

  // Storage edge into an empty, unstalled queue copies the chain within two cycles
  property p_store_copy;
    @(posedge mclk) disable iff (!nrst)
    (store_edge && !drain_valid && drain_ready) ##1 drain_ready
      |=> (par_out == $past(chain_reg, 2));
  endproperty
  a_store_copy: assert property (p_store_copy)
    else $error("storage edge not copied to outputs");

  // Clear alone leaves storage untouched
  property p_clear_keeps_store;
    @(posedge mclk) disable iff (!nrst)
    (clear_active && !drain_valid) |=> $stable(storage_reg);
  endproperty
  a_clear_keeps_store: assert property (p_clear_keeps_store)
    else $error("clear altered storage");

  // A stalled drain freezes storage while new patterns keep shifting
  property p_hold_freezes;
    @(posedge mclk) disable iff (!nrst)
    !drain_ready |=> $stable(storage_reg);
  endproperty
  a_hold_freezes: assert property (p_hold_freezes)
    else $error("storage moved during stall");

  // A falling shift clock never moves the chain
  property p_fall_no_shift;
    @(posedge mclk) disable iff (!nrst)
    ($fell(pins_s.shift_clk) && !clear_active) |=> $stable(chain_reg);
  endproperty
  a_fall_no_shift: assert property (p_fall_no_shift)
    else $error("chain moved on falling shift clock");

  // A falling storage clock never queues a capture
  property p_store_fall_quiet;
    @(posedge mclk) disable iff (!nrst)
    $fell(pins_s.store_clk) |=> (capture_level <= $past(capture_level));
  endproperty
  a_store_fall_quiet: assert property (p_store_fall_quiet)
    else $error("capture queued on falling storage clock");

  // Storage only ever changes through a drained capture
  property p_storage_cause;
    @(posedge mclk) disable iff (!nrst)
    !$stable(storage_reg) |-> $past(drain_valid && drain_ready);
  endproperty
  a_storage_cause: assert property (p_storage_cause)
    else $error("storage changed without a capture");

  // Every accepted storage edge adds exactly one queued capture
  property p_push_on_edge;
    @(posedge mclk) disable iff (!nrst)
    (store_edge && capture_ready) |=> (capture_level ==
      $past(capture_level) + 5'h01 - {4'h0, $past(drain_valid && drain_ready)});
  endproperty
  a_push_on_edge: assert property (p_push_on_edge)
    else $error("storage edge not queued");

  // Losing a capture is always reported on the next cycle
  property p_drop_flag;
    @(posedge mclk) disable iff (!nrst)
    (store_edge && !capture_ready) |=> capture_dropped;
  endproperty
  a_drop_flag: assert property (p_drop_flag)
    else $error("lost capture not reported");

  property p_drop_cause;
    @(posedge mclk) disable iff (!nrst)
    capture_dropped |-> $past(store_edge && !capture_ready);
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("drop reported without a lost capture");

  // Ready tracks the fill level; a full queue refuses
  property p_ready_level;
    @(posedge mclk) disable iff (!nrst)
    capture_ready == (capture_level < CAPTURE_DEPTH);
  endproperty
  a_ready_level: assert property (p_ready_level)
    else $error("queue ready disagrees with level");

  // Cascade output takes the next-to-last stage on a shift
  property p_cascade_shift;
    @(posedge mclk) disable iff (!nrst)
    (shift_edge && !clear_active) |=> (cascade_out == $past(chain_reg[LAST_STAGE-1]));
  endproperty
  a_cascade_shift: assert property (p_cascade_shift)
    else $error("cascade output did not follow the shift");

  property p_clear_cascade;
    @(posedge mclk) disable iff (!nrst)
    clear_active |=> !cascade_out;
  endproperty
  a_clear_cascade: assert property (p_clear_cascade)
    else $error("cascade output high after clear");

  // Disabling floats the outputs on the first cycle, not only the second
  property p_oe_release;
    @(posedge mclk) disable iff (!nrst)
    $rose(pins_s.oe_n) |=> !par_oe;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("parallel outputs still driven after disable");

endmodule : latched_shifter

// ==== rtl/pin_sampler.sv ====
`timescale 1ns/1ps
module pin_sampler
  import shifter_pkg::*;
#(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // Raw pins
  input  wire logic [W-1:0] pin_raw,
  // Synchronised levels and rising edges
  output logic      [W-1:0] pin_sync,
  output logic      [W-1:0] pin_rise
);
  import shifter_pkg::*;

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // First stage is read only by the second
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      prev_reg <= RST_VAL;
    else
      prev_reg <= sync_reg;
  end

  assign pin_sync = sync_reg;
  assign pin_rise = sync_reg & ~prev_reg;

endmodule : pin_sampler

// ==== rtl/shifter_pkg.sv ====
package shifter_pkg;

  // Shift chain and storage geometry
  localparam int NUM_STAGES = 8;
  localparam int LAST_STAGE = NUM_STAGES - 1;

  // Depth of the capture queue between the shift chain and the storage register
  localparam int CAPTURE_DEPTH = 16;

  // Flip-flops in front of any logic that reads a pin
  localparam int SYNC_STAGES = 2;

  // Pins sampled by mclk
  localparam int PIN_COUNT = 6;

  typedef logic [NUM_STAGES-1:0] stage_word_t;

  typedef struct packed {
    logic serial;
    logic shift_clk;
    logic clear_n;
    logic store_clk;
    logic oe_n;
    logic hold;
  } pin_in_t;

  // Idle pin levels while nrst is low: clear and enable inactive
  localparam pin_in_t PIN_IDLE = '{
    serial:    1'b0,
    shift_clk: 1'b0,
    clear_n:   1'b1,
    store_clk: 1'b0,
    oe_n:      1'b1,
    hold:      1'b0
  };

  localparam stage_word_t STAGE_ZERO = '0;

endpackage : shifter_pkg

// ==== verification/host_model.sv ====
`timescale 1ns/1ps
module host_model
  import shifter_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Pins toward the shifter
  output shifter_pkg::pin_in_t pins
);
  import shifter_pkg::*;

  initial
  begin
    pins = PIN_IDLE;
  end

  // One 80 ns link period, 40 ns low then 40 ns high; clocks idle between pulses
  // Data settles well before the rising edge and flips at the fall, so a late
  // sample of the data pin would show up as a wrong bit
  task automatic pulse(input logic sh, input logic st, input logic d);
    @(negedge mclk);
    pins.serial <= d;
    repeat (4) @(negedge mclk);
    pins.shift_clk <= sh;
    pins.store_clk <= st;
    repeat (5) @(negedge mclk);
    pins.shift_clk <= 1'b0;
    pins.store_clk <= 1'b0;
    pins.serial    <= ~d;
  endtask : pulse

  // Whole word, first bit out ends in bit 7; storage untouched meanwhile
  task automatic shift_word(input stage_word_t w);
    for (int i = LAST_STAGE; i >= 0; i--)
    begin
      pulse(1'b1, 1'b0, w[i]);
    end
  endtask : shift_word

  // Clear, enable and stall levels; clear settles before any later edge
  task automatic levels(input logic c, input logic o, input logic h);
    @(negedge mclk);
    pins.clear_n <= c;
    pins.oe_n    <= o;
    pins.hold    <= h;
    repeat (6) @(negedge mclk);
  endtask : levels
endmodule : host_model

// ==== verification/tb_latched_shifter.sv ====
`timescale 1ns/1ps
module tb_latched_shifter;
  import shifter_pkg::*;

  logic        mclk;
  logic        nrst;
  pin_in_t     pins;
  stage_word_t par_out;
  logic        par_oe;
  logic        cascade_out;
  logic        capture_ready;
  logic        capture_dropped;
  logic [4:0]  capture_level;
  wire  [7:0]  par_pins;
  int          fail_count;
  int          compares;

  // Three-state wire as a load would see it
  assign par_pins = par_oe ? par_out : 8'hZZ;

  host_model host_u (.mclk(mclk), .pins(pins));

  latched_shifter dut_u (
    .mclk(mclk), .nrst(nrst),
    .shift_data_in(pins.serial), .shift_clock(pins.shift_clk),
    .shift_clear_n(pins.clear_n), .storage_clock(pins.store_clk),
    .output_enable_n(pins.oe_n), .update_hold(pins.hold),
    .par_out(par_out), .par_oe(par_oe), .cascade_out(cascade_out),
    .capture_ready(capture_ready), .capture_dropped(capture_dropped),
    .capture_level(capture_level)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Contents are undefined after power-up: clear and latch zeros first
  task automatic t_start();
    chk(capture_level, 5'h00);
    host_u.levels(1'b0, 1'b0, 1'b0);
    host_u.pulse(1'b0, 1'b1, 1'b0);
    chk(par_out, 8'h00);
    chk(cascade_out, 1'b0);
    host_u.levels(1'b1, 1'b0, 1'b0);
  endtask : t_start

  // Load one word, then shift the next while the first stays shown
  task automatic t_load();
    host_u.shift_word(8'hA5);
    host_u.pulse(1'b0, 1'b1, 1'b0);
    chk(par_pins, 8'hA5);
    host_u.shift_word(8'hC3);
    chk(par_out, 8'hA5);
    chk(cascade_out, 1'b1);
    host_u.pulse(1'b0, 1'b1, 1'b0);
    chk(par_out, 8'hC3);
  endtask : t_load

  // Both clocks on one pulse: storage lags one shift
  task automatic t_tied();
    host_u.pulse(1'b1, 1'b1, 1'b0);
    chk(par_out, 8'hC3);
    host_u.pulse(1'b0, 1'b1, 1'b0);
    chk(par_out, 8'h86);
  endtask : t_tied

  // Clear wins over a shift edge and leaves storage alone until latched
  task automatic t_clear();
    host_u.levels(1'b0, 1'b0, 1'b0);
    chk(cascade_out, 1'b0);
    chk(par_out, 8'h86);
    host_u.pulse(1'b1, 1'b0, 1'b1);
    chk(cascade_out, 1'b0);
    host_u.pulse(1'b0, 1'b1, 1'b0);
    chk(par_out, 8'h00);
    host_u.levels(1'b1, 1'b0, 1'b0);
    host_u.shift_word(8'h81);
  endtask : t_clear

  // Enable high floats the parallel wire, cascade stays driven
  task automatic t_oe();
    host_u.levels(1'b1, 1'b1, 1'b0);
    chk(par_oe, 1'b0);
    chk(par_pins, 8'hZZ);
    chk(cascade_out, 1'b1);
    host_u.levels(1'b1, 1'b0, 1'b0);
    chk(par_pins, 8'h00);
  endtask : t_oe

  // Stalled queue fills to 16, the next capture is lost, then drains
  task automatic t_fifo();
    logic seen;
    int   n;
    seen = 1'b0;
    host_u.levels(1'b1, 1'b0, 1'b1);
    // Tied clocks shifting ones: the last queued capture is the all-ones chain
    repeat (CAPTURE_DEPTH) host_u.pulse(1'b1, 1'b1, 1'b1);
    chk(capture_level, 5'h10);
    chk(capture_ready, 1'b0);
    chk(par_out, 8'h00);
    fork
      host_u.pulse(1'b0, 1'b1, 1'b0);
      repeat (12) @(negedge mclk) if (capture_dropped === 1'b1) seen = 1'b1;
    join
    chk(seen, 1'b1);
    chk(capture_level, 5'h10);
    host_u.levels(1'b1, 1'b0, 1'b0);
    n = 0;
    while (capture_level !== 5'h00 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    repeat (3) @(negedge mclk);
    chk(capture_level, 5'h00);
    chk(capture_ready, 1'b1);
    chk(par_out, 8'hFF);
  endtask : t_fifo

  // Tests need about 600 cycles; the limit leaves a wide margin
  initial
  begin
    #100us;
    fail_count++;
    test_done();
  end

  initial
  begin
    nrst       = 1'b0;
    fail_count = 0;
    compares   = 0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    t_start();
    t_load();
    t_tied();
    t_clear();
    t_oe();
    t_fifo();
    test_done();
  end
endmodule : tb_latched_shifter
